// *** rtl/bcsc_capture.sv ***
/*
  bar-code capture: receives scanned codes on the screen-transfer serial
  port and packs them into consecutive words for the controller cpu.
  assumes the cpu side takes writes by valid/ready and the option strap
  comes from logic on the same clock.
*/
// Summary of operation
// - forward each scanned code as cpu word writes
// - count at base, bytes from base+1, low first
// - odd count: pad last upper byte with space
// - network option attached disables the reader function
// - reader data arrives on screen-transfer port
`timescale 1ns/1ns
module bcsc_capture import bcsc_pkg::*; #(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF,
  parameter logic [CNT_W-1:0] MAX_BYTES = MAX_BYTES_DEF
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic screen_rxd_in,
  input wire logic net_link_attached_in,
  input wire logic [ADDR_W-1:0] base_dev_in,
  input wire logic wr_ready_in,
  input wire logic err_clear_in,
  output logic wr_valid_out,
  output logic [ADDR_W-1:0] wr_addr_out,
  output logic [WORD_W-1:0] wr_data_out,
  output logic rts_out,
  output logic code_done_out,
  output logic parity_err_out,
  output logic frame_err_out,
  output logic overrun_err_out
);
  ////////////////////////////////////////////////////////////////////////
  // receiver on the screen-transfer port
  logic [7:0] rx_byte;
  logic rx_valid, rx_perr, rx_ferr;
  bcsc_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) i_bcsc_uart_rx (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .rxd_in(screen_rxd_in),
    .byte_out(rx_byte),
    .valid_out(rx_valid),
    .perr_out(rx_perr),
    .ferr_out(rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////////
  // capture state
  bcsc_state_type state_q, state_d;
  logic [CNT_W-1:0] count_q; // bytes stored in this code
  logic [ADDR_W-1:0] idx_q; // next word index
  logic odd_q; // a low byte is waiting
  logic [7:0] lo_q; // the waiting low byte

  // decode of the incoming character
  wire byte_ok = rx_valid && !rx_perr && !rx_ferr;
  wire is_cr = (rx_byte == CHAR_CR);
  wire in_recv = (state_q == ST_RECV);
  // room left in the code and a free write slot
  wire room = (count_q < MAX_BYTES);
  wire wr_free = !wr_valid_out || wr_ready_in;
  // a data byte is taken only while there is room; an upper byte also needs a free write slot
  wire data_byte = in_recv && byte_ok && !is_cr;
  wire take_byte = data_byte && room && (!odd_q || wr_free);
  // which write is staged this cycle
  wire stage_word = take_byte && odd_q;
  wire stage_pad = (state_q == ST_PAD) && wr_free;
  wire stage_cnt = (state_q == ST_CNT) && wr_free;
  wire stage_any = stage_word || stage_pad || stage_cnt;
  // a good byte that cannot be placed is counted as overrun, unless the option is attached
  wire overrun = byte_ok && !net_link_attached_in && !take_byte && !(in_recv && is_cr);

  // word address: data words sit above the count word
  wire [ADDR_W-1:0] data_addr = base_dev_in + DATA_OFFSET + idx_q;
  wire [ADDR_W-1:0] wr_addr_d = stage_cnt ? base_dev_in : data_addr;
  wire [WORD_W-1:0] wr_data_d = stage_cnt ? WORD_W'(count_q) :
                                stage_pad ? {CHAR_SPACE, lo_q} :
                                {rx_byte, lo_q};
  wire wr_valid_d = !net_link_attached_in && (stage_any || (wr_valid_out && !wr_ready_in));
  wire rts_d = in_recv && !net_link_attached_in && !wr_valid_out;

  ////////////////////////////////////////////////////////////////////////
  // next state of the capture sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF: state_d = ST_RECV;
      ST_RECV: if (in_recv && byte_ok && is_cr) state_d = odd_q ? ST_PAD : ST_CNT;
      ST_PAD: if (wr_free) state_d = ST_CNT;
      ST_CNT: if (wr_free) state_d = ST_RECV;
      default: state_d = ST_OFF;
    endcase
    // option attached: function held off
    if (net_link_attached_in) state_d = ST_OFF;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence registers and byte packing
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_OFF;
      count_q <= '0;
      idx_q <= '0;
      odd_q <= 1'b0;
      lo_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_d == ST_OFF || stage_cnt) begin
        // new code starts empty
        count_q <= '0;
        idx_q <= '0;
        odd_q <= 1'b0;
      end else if (take_byte) begin
        // low byte first, then upper byte completes the word
        count_q <= count_q + 1'b1;
        odd_q <= !odd_q;
        if (!odd_q) lo_q <= rx_byte;
        if (odd_q) idx_q <= idx_q + 1'b1;
      end else if (stage_pad) begin
        idx_q <= idx_q + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // cpu write staging and outputs
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_valid_out <= 1'b0;
      wr_addr_out <= '0;
      wr_data_out <= '0;
      rts_out <= 1'b0;
      code_done_out <= 1'b0;
    end else begin
      wr_valid_out <= wr_valid_d;
      if (stage_any) begin
        wr_addr_out <= wr_addr_d;
        wr_data_out <= wr_data_d;
      end
      // ready drops while a write waits or outside reception
      rts_out <= rts_d;
      code_done_out <= stage_cnt && !net_link_attached_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky error flags: a new event beats a clear
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      parity_err_out <= 1'b0;
      frame_err_out <= 1'b0;
      overrun_err_out <= 1'b0;
    end else begin
      parity_err_out <= (parity_err_out && !err_clear_in) || (rx_valid && rx_perr);
      frame_err_out <= (frame_err_out && !err_clear_in) || (rx_valid && rx_ferr);
      overrun_err_out <= (overrun_err_out && !err_clear_in) || overrun;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pad_start;
    stage_pad && !net_link_attached_in;
  endsequence

  sequence s_cnt_start;
    stage_cnt && !net_link_attached_in;
  endsequence

  AST_LOW_FIRST: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    stage_word && !net_link_attached_in |=>
      wr_valid_out && wr_data_out == {$past(rx_byte), $past(lo_q)})
    else $error("word not packed low byte first");

  AST_DATA_ADDR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    stage_word && !net_link_attached_in |=>
      wr_addr_out == $past(base_dev_in) + DATA_OFFSET + $past(idx_q))
    else $error("data word at wrong address");

  AST_PAD_SPACE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_pad_start |=> wr_valid_out && wr_data_out[15:8] == CHAR_SPACE && state_q == ST_CNT)
    else $error("odd code not padded with space");

  // a parity event always shows in the flag, even against a clear
  AST_PERR_SET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rx_valid && rx_perr |=> parity_err_out)
    else $error("parity event lost against clear");

  // a framing event always shows in the flag, even against a clear
  AST_FERR_SET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    rx_valid && rx_ferr |=> frame_err_out)
    else $error("framing event lost against clear");

  // ready only rises after a cycle of reception with the option absent
  AST_RTS_RISE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(rts_out) |-> $past(in_recv) && !$past(net_link_attached_in))
    else $error("ready raised outside reception");

  // the byte count never passes the code limit
  AST_COUNT_LIMIT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    count_q <= MAX_BYTES)
    else $error("byte count beyond limit");

  AST_COUNT_WORD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_cnt_start |=> wr_valid_out && wr_addr_out == $past(base_dev_in) &&
      wr_data_out == WORD_W'($past(count_q)) && code_done_out)
    else $error("count word wrong");

  AST_BLOCKED: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    net_link_attached_in [*2] |-> !rts_out && !wr_valid_out && state_q == ST_OFF)
    else $error("reader active while network option attached");

  AST_RTS_BUSY: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wr_valid_out ##1 wr_valid_out |-> !rts_out)
    else $error("ready shown while write pending");

  AST_CR_END: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    in_recv && byte_ok && is_cr && !net_link_attached_in && wr_ready_in |=>
      ##[0:2] code_done_out)
    else $error("terminator did not close the code");
endmodule // bcsc_capture

// *** rtl/bcsc_pkg.sv ***
/*
  shared constants of the bar-code serial capture block: serial framing,
  character codes, word packing and timing.
  assumes a single 125 MHz system clock and an 8E1 reader at 9600 baud.
*/
package bcsc_pkg;
  // system clock and line rate
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BAUD = 9600;
  // bit time in clock cycles, derived from rate and clock
  localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / BAUD;
  // bit counter width
  localparam int CNT_W = 16;
  // data bits per character
  localparam logic [3:0] DATA_BITS = 4'h8;
  // word address and data widths
  localparam int ADDR_W = 16;
  localparam int WORD_W = 16;
  // terminator and pad characters
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  // characters start one word above the count word
  localparam logic [ADDR_W-1:0] DATA_OFFSET = 16'h0001;
  // default longest stored code in bytes
  localparam logic [CNT_W-1:0] MAX_BYTES_DEF = 16'h0100;
  // capture states
  typedef enum logic [1:0] {ST_OFF, ST_RECV, ST_PAD, ST_CNT} bcsc_state_type;
  // receiver states
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} bcsc_rx_type;
endpackage

// *** rtl/bcsc_uart_rx.sv ***
/*
  asynchronous 8E1 character receiver.
  assumes the line idles high and arrives unsynchronised from a pin.
*/
`timescale 1ns/1ns
module bcsc_uart_rx import bcsc_pkg::*; #(
  parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic rxd_in,
  output logic [7:0] byte_out,
  output logic valid_out,
  output logic perr_out,
  output logic ferr_out
);
  // three-stage synchroniser and filtered line
  logic s1_q, s2_q, s3_q, line_q;
  bcsc_rx_type st_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic perr_q;
  wire tick = (cnt_q == '0);
  wire [CNT_W-1:0] full_bit = CNT_W'(BIT_CYCLES - 1);
  wire [CNT_W-1:0] half_bit = CNT_W'(BIT_CYCLES / 2);

  ////////////////////////////////////////////////////////////////////////
  // synchroniser: line moves only when stages two and three agree
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      line_q <= 1'b1;
    end else begin
      s1_q <= rxd_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) line_q <= s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer: start, eight data lsb first, even parity, stop
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      sh_q <= '0;
      perr_q <= 1'b0;
      byte_out <= '0;
      valid_out <= 1'b0;
      perr_out <= 1'b0;
      ferr_out <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      cnt_q <= tick ? full_bit : cnt_q - 1'b1;
      case (st_q)
        RX_IDLE: begin
          // falling edge: aim at mid start bit
          if (!line_q) begin
            st_q <= RX_START;
            cnt_q <= half_bit;
          end
        end
        RX_START: begin
          // glitch check at mid start bit
          if (tick) begin
            st_q <= line_q ? RX_IDLE : RX_DATA;
            bit_q <= '0;
          end
        end
        RX_DATA: begin
          if (tick) begin
            sh_q <= {line_q, sh_q[7:1]};
            bit_q <= bit_q + 1'b1;
            if (bit_q == DATA_BITS - 1'b1) st_q <= RX_PAR;
          end
        end
        RX_PAR: begin
          // even parity: parity bit equals xor of data
          if (tick) begin
            perr_q <= line_q ^ (^sh_q);
            st_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (tick) begin
            byte_out <= sh_q;
            perr_out <= perr_q;
            ferr_out <= !line_q;
            valid_out <= 1'b1;
            st_q <= RX_IDLE;
          end
        end
        default: st_q <= RX_IDLE;
      endcase
    end
  end

  // a character is only delivered at the middle of a stop bit
  AST_RX_STOP: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    valid_out |-> $past(st_q) == RX_STOP)
    else $error("character delivered outside stop bit");
endmodule // bcsc_uart_rx

// *** test/bcsc_reader_model.sv ***
/*
  behavioural bar-code reader: sends 8e1 frames on its data line.
  assumes the bench calls send_byte and that rts comes from the device.
*/
`timescale 1ns/1ns
module bcsc_reader_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic rts_in,
  output logic txd_out
);
  // line idles at mark level between frames
  initial txd_out = 1'b1;
  ////////////////////////////////////////////////////////////////////
  // one bit time on the line, changed at a falling edge
  task automatic send_bit(input logic b);
    txd_out = b;
    repeat (BIT_CYCLES) @(negedge clk_in);
  endtask
  // one frame with its stop bit held low, then two idle bit times
  task automatic send_bad_stop(input logic [7:0] b);
    int i;
    @(negedge clk_in);
    while (rts_in !== 1'b1) @(negedge clk_in);
    send_bit(1'b0);
    for (i = 0; i < 8; i++) send_bit(b[i]);
    send_bit(^b);
    send_bit(1'b0);
    send_bit(1'b1);
    send_bit(1'b1);
  endtask
  // one frame: start, 8 data lsb first, even parity, stop
  task automatic send_byte(input logic [7:0] b, input logic bad_par);
    int i;
    @(negedge clk_in);
    while (rts_in !== 1'b1) @(negedge clk_in);
    send_bit(1'b0);
    for (i = 0; i < 8; i++) send_bit(b[i]);
    send_bit((^b) ^ bad_par);
    send_bit(1'b1);
  endtask
endmodule // bcsc_reader_model

// *** test/bcsc_capture_bench.sv ***
/*
  self-checking bench of the bar-code capture block.
  assumes the reader model file is compiled first.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module bcsc_capture_bench import bcsc_pkg::*;;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic net_link_attached_in = 1'b0;
  logic [ADDR_W-1:0] base_dev_in = 16'h0100;
  logic wr_ready_in = 1'b1;
  logic err_clear_in = 1'b0;
  logic rxd, wr_valid_out, rts_out, code_done_out, perr, ferr, oerr;
  logic [ADDR_W-1:0] wr_addr_out;
  logic [WORD_W-1:0] wr_data_out;
  logic [31:0] wq[$]; // accepted writes as {addr, data}
  int err_count = 0;
  int compares = 0;
  int done_cnt = 0; // count pulses seen
  int done_seen = 0; // count pulses already judged
  // 125 mhz clock
  always #4 clk_in = ~clk_in;
  bcsc_capture #(.BIT_CYCLES(16)) i_bcsc_capture (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .screen_rxd_in(rxd), .net_link_attached_in(net_link_attached_in),
    .base_dev_in(base_dev_in), .wr_ready_in(wr_ready_in), .err_clear_in(err_clear_in),
    .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out),
    .rts_out(rts_out), .code_done_out(code_done_out), .parity_err_out(perr),
    .frame_err_out(ferr), .overrun_err_out(oerr));
  bcsc_reader_model #(.BIT_CYCLES(16)) i_bcsc_reader_model (.clk_in(clk_in),
    .rts_in(rts_out), .txd_out(rxd));
  ////////////////////////////////////////////////////////////////////
  // record every write the cpu side takes and every count pulse
  always @(posedge clk_in) begin
    if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1) wq.push_back({wr_addr_out, wr_data_out});
    if (code_done_out === 1'b1) done_cnt++;
  end
  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded wait for exactly one more count write
  task automatic wait_done;
    int n;
    for (n = 0; n < 4000 && done_cnt == done_seen; n++) @(negedge clk_in);
    `CHK(done_cnt, done_seen + 1)
    done_seen = done_cnt;
    repeat (3) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////////
  // even code: two bytes packed low first, count at base
  task automatic t_even;
    wq.delete();
    i_bcsc_reader_model.send_byte(8'h41, 1'b0);
    i_bcsc_reader_model.send_byte(8'h42, 1'b0);
    i_bcsc_reader_model.send_byte(CHAR_CR, 1'b0);
    wait_done();
    `CHK(wq.size(), 2)
    `CHK(wq[0], {16'h0101, 16'h4241})
    `CHK(wq[1], {16'h0100, 16'h0002})
    $display("t_even done");
  endtask
  // odd code: last upper byte padded with space
  task automatic t_odd;
    wq.delete();
    @(negedge clk_in) base_dev_in = 16'h2000;
    i_bcsc_reader_model.send_byte(8'h5a, 1'b0);
    i_bcsc_reader_model.send_byte(CHAR_CR, 1'b0);
    wait_done();
    `CHK(wq.size(), 2)
    `CHK(wq[0], {16'h2001, 16'h205a})
    `CHK(wq[1], {16'h2000, 16'h0001})
    $display("t_odd done");
  endtask
  // cpu stall: write held, rts drops until accepted
  task automatic t_stall;
    wq.delete();
    @(negedge clk_in) wr_ready_in = 1'b0;
    i_bcsc_reader_model.send_byte(8'h31, 1'b0);
    i_bcsc_reader_model.send_byte(8'h32, 1'b0);
    repeat (20) @(negedge clk_in);
    `CHK(rts_out, 1'b0)
    `CHK(wr_valid_out, 1'b1)
    `CHK(wr_data_out, 16'h3231)
    wr_ready_in = 1'b1;
    i_bcsc_reader_model.send_byte(CHAR_CR, 1'b0);
    wait_done();
    `CHK(wq.size(), 2)
    `CHK(wq[0], {16'h2001, 16'h3231})
    `CHK(wq[1], {16'h2000, 16'h0002})
    `CHK(oerr, 1'b0)
    $display("t_stall done");
  endtask
  // bad parity: flag set, byte dropped, clear works
  task automatic t_parity;
    wq.delete();
    i_bcsc_reader_model.send_byte(8'h41, 1'b1);
    repeat (10) @(negedge clk_in);
    `CHK(perr, 1'b1)
    `CHK(wq.size(), 0)
    err_clear_in = 1'b1;
    @(negedge clk_in) err_clear_in = 1'b0;
    @(negedge clk_in);
    `CHK(perr, 1'b0)
    i_bcsc_reader_model.send_bad_stop(8'h41);
    repeat (10) @(negedge clk_in);
    `CHK(ferr, 1'b1)
    `CHK(perr, 1'b0)
    `CHK(wq.size(), 0)
    err_clear_in = 1'b1;
    @(negedge clk_in) err_clear_in = 1'b0;
    @(negedge clk_in);
    `CHK(ferr, 1'b0)
    $display("t_parity done");
  endtask
  // network option attached: reader function off
  task automatic t_option;
    @(negedge clk_in) net_link_attached_in = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK(rts_out, 1'b0)
    `CHK(wr_valid_out, 1'b0)
    net_link_attached_in = 1'b0;
    repeat (4) @(negedge clk_in);
    `CHK(rts_out, 1'b1)
    $display("t_option done");
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    `CHK(rts_out, 1'b1)
    t_even();
    t_odd();
    t_stall();
    t_parity();
    t_option();
    finish_test();
  end
  // watchdog: about 25 times the expected run
  initial begin
    #400000;
    err_count++;
    finish_test();
  end
endmodule // bcsc_capture_bench
